// >>> verilog/sadc_regs.svh
// constants for the serial converter control block
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH
`define SADC_RES_BITS 14
`define SADC_FRAME_EDGES 5'd16
`define SADC_FIRST_BIT_EDGE 5'd3
`define SADC_NAP_COUNT 3'd2
`define SADC_SLEEP_COUNT 3'd4
`define SADC_CLK_PERIOD_NS 10
`define SADC_REF_SETTLE_MS 2
`define SADC_REF_SETTLE_CYC ((`SADC_REF_SETTLE_MS * 1000000) / `SADC_CLK_PERIOD_NS)
`define SADC_FIFO_DEPTH 8
`endif

// >>> verilog/sadc_pkg.sv
// types for the serial converter control block
`default_nettype none
package sadc_pkg;
	typedef enum logic [1:0] {
		SADC_ACTIVE,
		SADC_NAP,
		SADC_SLEEP
	} sadc_pwr_t;
endpackage
`default_nettype wire

// >>> verilog/sadc_fifo_if.sv
// stream carrier between the sample source and the result fifo
`timescale 1ns/1ps
`default_nettype none
interface sadc_fifo_if #(parameter int W = 14) ();
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> verilog/sadc_fifo.sv
// parameterised fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sadc_fifo #(
	parameter int W = 14,
	parameter int D = 8
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	sadc_fifo_if.snk in_if,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_q [D];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	// honest full and empty from the occupancy count
	assign in_if.ready = (cnt_q < (AW+1)'(D));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem_q[rd_q];
	assign push = in_if.valid && in_if.ready;
	assign pop = out_valid_o && out_ready_i;

	// storage needs no reset, only pointers and the count do
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_if.data;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// >>> verilog/sadc_ctrl.sv
// digital control of the serial sampling converter: coding, framing, power-down
//
// Contract
// - over positive full scale gives largest positive code
// - under negative full scale gives most negative code
// - results coded two's complement, 12 or 14 bits
// - code transitions lie midway between integer steps
// - comes up active after power-up
// - two strobes without clock edge enter nap
// - reference stays powered while napping
// - clock edge leaves nap at once
// - four strobes without clock edge enter sleep
// - clock edge wakes sleep; reference settles 2 ms
// - three wires: clock, strobe in, data out
// - strobe starts conversion; retrigger ignored for 16 clocks
// - result shifts out msb first from third edge
// - data output released whenever not sending bits; the code keeps the last bit driven until the next clock rise after the frame
// - bit valid by next rising clock edge
`include "sadc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl #(
	parameter int RES = `SADC_RES_BITS,
	parameter int SETTLE_CYC = `SADC_REF_SETTLE_CYC
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic sclk_i,
	input wire logic conversion_strobe_i,
	input wire logic signed [15:0] ain_code_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	output logic core_on_o,
	output logic ref_on_o,
	output logic ref_settled_o,
	output logic res_valid_o,
	output logic [RES-1:0] res_data_o,
	input wire logic res_ready_i
);
	localparam logic signed [15:0] POS_MAX = 16'sh7fff >>> (16 - RES);
	// arithmetic shift keeps the sign, so no negation is needed here
	localparam logic signed [15:0] NEG_MIN = 16'sh8000 >>> (16 - RES);

	logic [2:0] sck_s_q;
	logic [2:0] cnv_s_q;
	logic sck_lvl_q;
	logic cnv_lvl_q;
	logic sck_rise;
	logic cnv_rise;
	logic busy_q;
	logic [4:0] edge_q;
	logic [RES-1:0] shift_q;
	logic [2:0] pd_cnt_q;
	sadc_pkg::sadc_pwr_t pwr_q;
	logic [31:0] settle_q;
	logic sdo_q;
	logic oe_q;
	logic [RES-1:0] sample;
	logic strobe_ok;

	sadc_fifo_if #(.W(RES)) fifo_if ();

	// clamp the held input to the code range; it is already quantised, so no rounding is done here
	function automatic logic [RES-1:0] sadc_code(input logic signed [15:0] v);
		logic signed [15:0] c;
		c = v;
		if (v > POS_MAX) begin
			c = POS_MAX;
		end else if (v < NEG_MIN) begin
			c = NEG_MIN;
		end
		return c[RES-1:0];
	endfunction

	// three-stage synchronisers; an edge counts once stages two and three agree
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sck_s_q <= 3'h0;
			cnv_s_q <= 3'h0;
			sck_lvl_q <= 1'b0;
			cnv_lvl_q <= 1'b0;
		end else begin
			sck_s_q <= {sck_s_q[1:0], sclk_i};
			cnv_s_q <= {cnv_s_q[1:0], conversion_strobe_i};
			if (sck_s_q[1] == sck_s_q[2]) begin
				sck_lvl_q <= sck_s_q[2];
			end
			if (cnv_s_q[1] == cnv_s_q[2]) begin
				cnv_lvl_q <= cnv_s_q[2];
			end
		end
	end

	assign sck_rise = (sck_s_q[1] == sck_s_q[2]) && sck_s_q[2] && !sck_lvl_q;
	assign cnv_rise = (cnv_s_q[1] == cnv_s_q[2]) && cnv_s_q[2] && !cnv_lvl_q;
	// the input is an already quantised sample; midpoint thresholds live upstream
	assign sample = sadc_code(ain_code_i);
	assign strobe_ok = cnv_rise && !busy_q && !sck_rise;

	// conversion framing: a strobe is ignored until 16 clock edges pass
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy_q <= 1'b0;
			edge_q <= 5'h0;
			shift_q <= '0;
		end else if (strobe_ok) begin
			busy_q <= 1'b1;
			edge_q <= 5'h0;
			shift_q <= sample;
		end else if (busy_q && sck_rise) begin
			edge_q <= edge_q + 5'h1;
			if (edge_q + 5'h1 == `SADC_FRAME_EDGES) begin
				busy_q <= 1'b0;
			end
			// shift on the same edge that presents a bit, so the next edge sees the next one
			if (edge_q + 5'h1 >= `SADC_FIRST_BIT_EDGE) begin
				shift_q <= {shift_q[RES-2:0], 1'b0};
			end
		end
	end

	// data pin: each bit stands until the next clock rise, so a receiver latching
	// on the falling edge still sees the last bit after the frame has ended
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sdo_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (sck_rise) begin
			if (busy_q && edge_q + 5'h1 >= `SADC_FIRST_BIT_EDGE
				&& edge_q + 5'h1 < `SADC_FIRST_BIT_EDGE + 5'(RES)) begin
				sdo_q <= shift_q[RES-1];
				oe_q <= 1'b1;
			end else begin
				sdo_q <= 1'b0;
				oe_q <= 1'b0;
			end
		end
	end

	// power-down counter; a clock edge in the same cycle wins over a strobe
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pd_cnt_q <= 3'h0;
		end else if (sck_rise) begin
			pd_cnt_q <= 3'h0;
		end else if (cnv_rise && pd_cnt_q < `SADC_SLEEP_COUNT) begin
			pd_cnt_q <= pd_cnt_q + 3'h1;
		end
	end

	// power state follows the counter; waking is immediate on a clock edge
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pwr_q <= sadc_pkg::SADC_ACTIVE;
		end else if (sck_rise) begin
			pwr_q <= sadc_pkg::SADC_ACTIVE;
		end else if (pd_cnt_q >= `SADC_SLEEP_COUNT) begin
			pwr_q <= sadc_pkg::SADC_SLEEP;
		end else if (pd_cnt_q >= `SADC_NAP_COUNT) begin
			pwr_q <= sadc_pkg::SADC_NAP;
		end
	end

	// reference settling count after leaving sleep; reloaded every cycle spent in sleep
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			settle_q <= 32'h0;
		end else if (pwr_q == sadc_pkg::SADC_SLEEP) begin
			settle_q <= 32'(SETTLE_CYC);
		end else if (settle_q != 32'h0) begin
			settle_q <= settle_q - 32'h1;
		end
	end

	// status outputs, all registered
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			core_on_o <= 1'b1;
			ref_on_o <= 1'b1;
			ref_settled_o <= 1'b1;
		end else begin
			core_on_o <= (pwr_q == sadc_pkg::SADC_ACTIVE);
			ref_on_o <= (pwr_q != sadc_pkg::SADC_SLEEP);
			ref_settled_o <= (pwr_q != sadc_pkg::SADC_SLEEP) && (settle_q == 32'h0);
		end
	end

	assign sdo_o = sdo_q;
	assign sdo_oe_o = oe_q;

	// every accepted sample also goes to the fifo; a full fifo drops it
	assign fifo_if.valid = strobe_ok;
	assign fifo_if.data = sample;

	sadc_fifo #(.W(RES), .D(`SADC_FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.in_if(fifo_if),
		.out_valid_o(res_valid_o),
		.out_ready_i(res_ready_i),
		.out_data_o(res_data_o)
	);

	a_sdo_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(!busy_q && (sck_rise || !oe_q)) |=> !oe_q)
		else $error("data pin driven while idle");
	a_nap_entry: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(pd_cnt_q == 3'd2 && !sck_rise) |=> pwr_q != sadc_pkg::SADC_ACTIVE)
		else $error("nap not entered");
	a_sleep_entry: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(pd_cnt_q == 3'd4 && !sck_rise) |=> pwr_q == sadc_pkg::SADC_SLEEP)
		else $error("sleep not entered");
	a_wake_fast: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		sck_rise |=> pwr_q == sadc_pkg::SADC_ACTIVE) else $error("no wake");
	a_cnt_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		sck_rise |=> pd_cnt_q == 3'h0) else $error("counter not cleared");
	a_nap_ref: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		pwr_q == sadc_pkg::SADC_NAP |=> ref_on_o && !core_on_o)
		else $error("reference off in nap");
	a_retrig_ignore: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(busy_q && cnv_rise && !sck_rise) |=> edge_q == $past(edge_q))
		else $error("strobe restarted frame");
	a_clamp_pos: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ain_code_i > POS_MAX |-> sample == POS_MAX[RES-1:0])
		else $error("positive clamp wrong");
	a_clamp_neg: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ain_code_i < NEG_MIN |-> sample == NEG_MIN[RES-1:0])
		else $error("negative clamp wrong");
endmodule
`default_nettype wire

// >>> sim/sadc_host_model.sv
// far-side controller model: drives serial clock and strobe, reads data
`timescale 1ns/1ps
`default_nettype none
module sadc_host_model (
	input wire logic clk_i,
	input wire logic sdo_i,
	output logic sclk_o,
	output logic strobe_o
);
	// three wires; serial clock stands still outside frames
	initial begin
		sclk_o = 1'b0;
		strobe_o = 1'b0;
	end
	// strobe pulse, four cycles high then four low; callers space frames apart
	task automatic strobe_pulse();
		@(posedge clk_i) strobe_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		strobe_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		#1;
	endtask
	// one 80 ns period; data taken just before the next rise, where it must hold
	task automatic sclk_pulse(output logic b);
		@(posedge clk_i) sclk_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		sclk_o <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1 b = sdo_i;
	endtask
endmodule
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int SETTLE = 50;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic signed [15:0] ain = 16'sh0000;
	logic res_ready = 1'b0;
	logic last_bit = 1'b0;
	logic sclk, strobe, sdo, sdo_oe, core_on, ref_on, settled, res_valid;
	logic [13:0] res_data;
	wire logic sdo_line;
	int num_errors = 0;
	int comparisons = 0;
	int exp_q[$];
	always #5 clk_i = ~clk_i;
	// a released line shows the inverse of its last level, never a stale value
	always @(posedge clk_i) if (sdo_oe) last_bit <= sdo;
	assign sdo_line = sdo_oe ? sdo : ~last_bit;
	sadc_ctrl #(.RES(14), .SETTLE_CYC(SETTLE)) sadc_ctrl_inst (.clk_i(clk_i),
		.arst_n_i(arst_n_i), .sclk_i(sclk), .conversion_strobe_i(strobe),
		.ain_code_i(ain), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .core_on_o(core_on),
		.ref_on_o(ref_on), .ref_settled_o(settled), .res_valid_o(res_valid),
		.res_data_o(res_data), .res_ready_i(res_ready));
	sadc_host_model sadc_host_model_inst (.clk_i(clk_i), .sdo_i(sdo_line),
		.sclk_o(sclk), .strobe_o(strobe));
	task automatic note(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		note(got, exp);
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		note({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic wrap_up();
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// n strobes without clock, then a 17-period frame; expected code clamped here
	task automatic frame(input int v, input int n, input bit retrig);
		logic b;
		logic [13:0] w;
		int c;
		c = v > 8191 ? 8191 : (v < -8192 ? -8192 : v);
		w = 14'h0000;
		@(posedge clk_i) ain <= 16'(v);
		repeat (n) sadc_host_model_inst.strobe_pulse();
		if (exp_q.size() < 8) exp_q.push_back(c & 16'h3fff);
		chk_flag(core_on, n < 2);
		chk_flag(ref_on, n < 4);
		for (int r = 1; r <= 17; r++) begin
			if (retrig && r == 8) sadc_host_model_inst.strobe_pulse();
			sadc_host_model_inst.sclk_pulse(b);
			chk_flag(sdo_oe, r >= 3 && r <= 16);
			if (r >= 3 && r <= 16) w = {w[12:0], b};
			if (r == 1) chk_flag(core_on, 1'b1);
			if (r == 1) chk_flag(settled, n < 4);
		end
		chk_word({2'b00, w}, 16'(c & 16'h3fff));
		chk_flag(settled, 1'b1);
	endtask
	// hang guard, far beyond the expected 1600 or so cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		wrap_up();
	end
	// main sequence: reset, frames into a stalled fifo, then a random drain
	initial begin
		int vals[10];
		int ns[10];
		void'($urandom(78));
		vals = '{8191, -8192, 9000, -9000, 0, 1, -1, 0, 0, 0};
		ns = '{1, 2, 4, 1, 2, 1, 4, 1, 1, 1};
		repeat (10) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		#1;
		chk_flag(sdo_oe, 1'b0);
		chk_flag(core_on, 1'b1);
		chk_flag(ref_on, 1'b1);
		chk_flag(res_valid, 1'b0);
		for (int i = 0; i < 10; i++) begin
			if (i >= 7) vals[i] = int'($urandom_range(18000)) - 9000;
			frame(vals[i], ns[i], i == 5);
		end
		for (int k = 0; k < 300 && exp_q.size() > 0; k++) begin
			@(posedge clk_i) res_ready <= 1'($urandom_range(1));
			#1;
			if (res_valid === 1'b1 && res_ready) chk_word({2'b00, res_data}, 16'(exp_q.pop_front()));
		end
		@(posedge clk_i) res_ready <= 1'b0;
		#1;
		chk_word(16'(exp_q.size()), 16'h0000);
		chk_flag(res_valid, 1'b0);
		wrap_up();
	end
endmodule
`default_nettype wire
